// File: common/cfpw_pkg.sv
// Constants, register map and carrier types of the CPU frequency
// program and watchdog block.
// Assumes a 25 MHz system clock and a 14.318 MHz reference clock.
package cfpw_pkg;

    // ****************************************
    // Clock rates and times
    // ****************************************
    localparam int SYS_CLK_KHZ    = 25000;
    localparam int REF_CLK_KHZ    = 14318;
    localparam int SHORT_UNIT_MS  = 150;
    localparam int LONG_UNIT_MS   = 2500;
    localparam int SHORT_UNIT_CYC = SHORT_UNIT_MS * REF_CLK_KHZ;
    localparam int LONG_UNIT_CYC  = LONG_UNIT_MS * REF_CLK_KHZ;
    localparam int RST_PULSE_NS   = 1000;
    localparam int RST_PULSE_CYC  = (RST_PULSE_NS * SYS_CLK_KHZ + 999999) / 1000000;
    localparam int PRESC_W        = 26;
    localparam int RSTC_W         = 8;

    // ****************************************
    // Register map (command byte offsets)
    // ****************************************
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_SEL     = 8'h01;
    localparam logic [7:0] REG_CPU_N   = 8'h02;
    localparam logic [7:0] REG_CPU_M   = 8'h03;
    localparam logic [7:0] REG_REC_N   = 8'h04;
    localparam logic [7:0] REG_REC_M   = 8'h05;
    localparam logic [7:0] REG_WD_CNT  = 8'h06;
    localparam logic [7:0] REG_PINS    = 8'h07;

    // Control byte fields
    localparam int CTL_PROG_EN  = 0;
    localparam int CTL_OVERRIDE = 1;
    localparam int CTL_REC_SRC  = 2;
    localparam int CTL_WATCHDOG_ENABLE    = 3;
    localparam int CTL_WD_PRE   = 4;
    localparam int CTL_RST_WD   = 5;
    localparam int CTL_RST_FC   = 6;
    localparam int CTL_TO_FLAG  = 7;

    // Reset values and bus address
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [4:0] SEL_RST      = 5'h00;
    localparam logic [7:0] N_RST        = 8'h00;
    localparam logic [6:0] M_RST        = 7'h00;
    localparam logic [4:0] WD_CNT_RST   = 5'h00;
    localparam logic [6:0] SMB_ADDR_DEF = 7'h2A; // Arbitrary value

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic       prog;
        logic [4:0] sel;
        logic [7:0] n;
        logic [6:0] m;
    } cfpw_freq_t;

    typedef struct packed {
        logic       en;
        logic       pre;
        logic [4:0] cnt;
    } cfpw_wdcfg_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [4:0] sel;
        logic [7:0] cpu_n;
        logic [6:0] cpu_m;
        logic [7:0] rec_n;
        logic [6:0] rec_m;
        logic [4:0] wd_cnt;
    } cfpw_regs_t;

    typedef enum logic [2:0] {
        SM_IDLE = 3'h0,
        SM_RX   = 3'h1,
        SM_ACK  = 3'h3,
        SM_TX   = 3'h2,
        SM_RACK = 3'h6
    } cfpw_smb_state_t;

    typedef enum logic [1:0] {
        BK_ADDR = 2'h0,
        BK_CMD  = 2'h1,
        BK_DATA = 2'h3
    } cfpw_kind_t;

    typedef enum logic [1:0] {
        WD_OFF = 2'h0,
        WD_ARM = 2'h1,
        WD_RUN = 2'h3
    } cfpw_wd_state_t;

endpackage : cfpw_pkg

// File: hdl/cfpw_top.sv
// CPU frequency program, recovery frequency and watchdog control.
// Assumes SMBus pins oversampled on SYS_CLK and a free running REF_CLK.
//
// Contract
// - Programmable mode uses written N and M
// - Either divider byte update starts frequency load
// - Ratio from latched pins or override select
// - Recovery source uses recovery N and M
// - Recovery ratio from pins or select field
// - Either recovery byte update starts loading while in recovery with recovery source set
// - Watchdog disable stops and reloads counter
// - Enabled watchdog counts after frequency change
// - Timeout flag reads set, write one clears
// - Five bit count in prescaler units
// - Prescale select chooses short or long unit
// - Count reaching zero sets timeout flag
// - Reset pulse on timeout when enabled
// - Reset pulse on frequency change when enabled
// - Frequency is gear times (N+3)/(M+3)
// - Gear constant from pins or select bits
// - Powers up with programmable mode off
// - Timeout switches to recovery frequency
`timescale 1ns/1ps
module cfpw_top #(
    parameter int unsigned PRE_SHORT_CYC = cfpw_pkg::SHORT_UNIT_CYC,
    parameter int unsigned PRE_LONG_CYC  = cfpw_pkg::LONG_UNIT_CYC,
    parameter logic [6:0]  SMB_ADDR      = cfpw_pkg::SMB_ADDR_DEF
) (
    input  wire logic                 SYS_CLK,
    input  wire logic                 SYS_RST,
    input  wire logic                 REF_CLK,
    input  wire logic [4:0]           FS_PINS,
    input  wire logic                 SMB_CLK_IN,
    input  wire logic                 SMB_DAT_IN,
    output logic                      SMB_DAT_OUT,
    output logic                      SMB_DAT_OE_N,
    output cfpw_pkg::cfpw_freq_t      FREQ_OUT,
    output logic                      FREQ_LOAD,
    output logic                      SYS_RESET_N,
    output logic                      WD_TIMEOUT
);
    import cfpw_pkg::*;

    if (PRE_SHORT_CYC < 1 || PRE_LONG_CYC < 1 || PRE_LONG_CYC > (2**PRESC_W)) begin : g_chk
        $error("Prescaler lengths out of range");
    end

    localparam logic [PRESC_W-1:0] SHORT_LAST = PRESC_W'(PRE_SHORT_CYC - 1);
    localparam logic [PRESC_W-1:0] LONG_LAST  = PRESC_W'(PRE_LONG_CYC - 1);
    localparam logic [RSTC_W-1:0]  RST_LEN    = RSTC_W'(RST_PULSE_CYC);

    // ****************************************
    // Pin and crossing synchronisers
    // ****************************************
    logic       scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic [4:0] fs_m, fs_s;
    logic       to_m, to_s, to_p, ack_m, ack_s;
    logic       rrst_m, rrst_s, req_m, req_s, fc_m, fc_s, fc_p;
    logic       to_tgl_q, ack_q, req_q, fc_tgl_q;

    always_ff @(posedge SYS_CLK) begin
        {scl_p, scl_s, scl_m} <= {scl_s, scl_m, SMB_CLK_IN};
        {sda_p, sda_s, sda_m} <= {sda_s, sda_m, SMB_DAT_IN};
        {fs_s, fs_m}          <= {fs_m, FS_PINS};
        {to_p, to_s, to_m}    <= {to_s, to_m, to_tgl_q};
        {ack_s, ack_m}        <= {ack_m, ack_q};
    end

    always_ff @(posedge REF_CLK) begin
        {rrst_s, rrst_m}   <= {rrst_m, SYS_RST};
        {req_s, req_m}     <= {req_m, req_q};
        {fc_p, fc_s, fc_m} <= {fc_s, fc_m, fc_tgl_q};
    end

    // ****************************************
    // SMBus slave
    // ****************************************
    cfpw_smb_state_t sm_q, sm_d;
    cfpw_kind_t      kind_q, kind_d;
    logic [3:0]      bit_q, bit_d;
    logic [7:0]      sh_q, sh_d, ptr_q, ptr_d;
    logic            rd_q, rd_d, oen_q, oen_d, dout_q;
    logic            wr_stb;
    logic            scl_rise, scl_fall, start, stop;

    cfpw_regs_t  regs_q, regs_d;
    logic        flag_q, flag_d, rec_q, rec_d;
    logic [4:0]  pins_q, pins_d;
    logic [1:0]  lcnt_q, lcnt_d;

    function automatic logic [7:0] rd_byte(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            REG_CTRL:   v = {flag_q, regs_q.ctrl[6:0]};
            REG_SEL:    v = {3'h0, regs_q.sel};
            REG_CPU_N:  v = regs_q.cpu_n;
            REG_CPU_M:  v = {1'h0, regs_q.cpu_m};
            REG_REC_N:  v = regs_q.rec_n;
            REG_REC_M:  v = {1'h0, regs_q.rec_m};
            REG_WD_CNT: v = {3'h0, regs_q.wd_cnt};
            REG_PINS:   v = {3'h0, pins_q};
            default:    v = 8'h00;
        endcase
        return v;
    endfunction : rd_byte

    always_comb begin
        sm_d     = sm_q;
        kind_d   = kind_q;
        bit_d    = bit_q;
        sh_d     = sh_q;
        ptr_d    = ptr_q;
        rd_d     = rd_q;
        oen_d    = oen_q;
        wr_stb   = 1'b0;
        scl_rise = scl_s & ~scl_p;
        scl_fall = ~scl_s & scl_p;
        start    = scl_s & scl_p & sda_p & ~sda_s;
        stop     = scl_s & scl_p & ~sda_p & sda_s;
        if (start) begin
            sm_d   = SM_RX;
            kind_d = BK_ADDR;
            bit_d  = 4'h0;
            oen_d  = 1'b1;
        end else if (stop) begin
            sm_d  = SM_IDLE;
            oen_d = 1'b1;
        end else begin
            unique case (sm_q)
                SM_IDLE: ;
                SM_RX: begin
                    if (scl_rise && bit_q != 4'h8) begin
                        sh_d  = {sh_q[6:0], sda_s};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        if (kind_q == BK_ADDR && sh_q[7:1] != SMB_ADDR) begin
                            sm_d = SM_IDLE;
                        end else begin
                            sm_d  = SM_ACK;
                            oen_d = 1'b0;
                            unique case (kind_q)
                                BK_ADDR: rd_d = sh_q[0];
                                BK_CMD:  ptr_d = sh_q;
                                default: begin
                                    wr_stb = 1'b1;
                                    ptr_d  = ptr_q + 8'h01;
                                end
                            endcase
                        end
                    end
                end
                SM_ACK: begin
                    if (scl_fall) begin
                        bit_d = 4'h0;
                        if (rd_q) begin
                            sh_d  = rd_byte(ptr_q);
                            ptr_d = ptr_q + 8'h01;
                            oen_d = sh_d[7];
                            sm_d  = SM_TX;
                        end else begin
                            oen_d  = 1'b1;
                            sm_d   = SM_RX;
                            kind_d = (kind_q == BK_ADDR) ? BK_CMD : BK_DATA;
                        end
                    end
                end
                SM_TX: begin
                    if (scl_rise) begin
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        oen_d = 1'b1;
                        bit_d = 4'h0;
                        sm_d  = SM_RACK;
                    end else if (scl_fall) begin
                        sh_d  = {sh_q[6:0], 1'b1};
                        oen_d = sh_d[7];
                    end
                end
                SM_RACK: begin
                    // Master NACK ends the read burst
                    if (scl_rise && sda_s) begin
                        sm_d = SM_IDLE;
                    end else if (scl_fall) begin
                        sh_d  = rd_byte(ptr_q);
                        ptr_d = ptr_q + 8'h01;
                        oen_d = sh_d[7];
                        sm_d  = SM_TX;
                    end
                end
                default: sm_d = SM_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            sm_q   <= SM_IDLE;
            kind_q <= BK_ADDR;
            bit_q  <= 4'h0;
            sh_q   <= 8'h00;
            ptr_q  <= 8'h00;
            rd_q   <= 1'b0;
            oen_q  <= 1'b1;
            dout_q <= 1'b0;
        end else begin
            sm_q   <= sm_d;
            kind_q <= kind_d;
            bit_q  <= bit_d;
            sh_q   <= sh_d;
            ptr_q  <= ptr_d;
            rd_q   <= rd_d;
            oen_q  <= oen_d;
            dout_q <= 1'b0;
        end
    end

    // ****************************************
    // Registers, frequency select, reset pulse
    // ****************************************
    cfpw_freq_t  eff_q, eff_d;
    cfpw_wdcfg_t xcfg_q, xcfg_d, wcfg_d;
    logic        load_q, load_d, req_d, fc_tgl_d, rstn_q, rstn_d;
    logic [RSTC_W-1:0] rstc_q, rstc_d;
    logic [4:0]  ratio_sel;
    logic        to_evt, nm_upd, host_fc;

    always_comb begin
        regs_d = regs_q;
        rec_d  = rec_q;
        pins_d = pins_q;
        lcnt_d = lcnt_q;
        to_evt = to_s ^ to_p;
        // Pins sampled once, after the synchroniser has filled
        if (lcnt_q != 2'h3) begin
            lcnt_d = lcnt_q + 2'h1;
            if (lcnt_q == 2'h2) pins_d = fs_s;
        end
        if (wr_stb) begin
            unique case (ptr_q)
                REG_CTRL:   regs_d.ctrl   = {1'b0, sh_q[6:0]};
                REG_SEL:    regs_d.sel    = sh_q[4:0];
                REG_CPU_N:  regs_d.cpu_n  = sh_q;
                REG_CPU_M:  regs_d.cpu_m  = sh_q[6:0];
                REG_REC_N:  regs_d.rec_n  = sh_q;
                REG_REC_M:  regs_d.rec_m  = sh_q[6:0];
                REG_WD_CNT: regs_d.wd_cnt = sh_q[4:0];
                default: ;
            endcase
        end
        // Set beats a clear in the same cycle
        flag_d = to_evt
                 | (flag_q & ~(wr_stb && ptr_q == REG_CTRL && sh_q[CTL_TO_FLAG]));
        if (to_evt) begin
            rec_d = 1'b1;
        end else if (wr_stb && (ptr_q == REG_CPU_N || ptr_q == REG_CPU_M)) begin
            rec_d = 1'b0;
        end
        ratio_sel = regs_d.ctrl[CTL_OVERRIDE] ? regs_d.sel : pins_q;
        eff_d.sel = ratio_sel;
        eff_d.n   = regs_d.cpu_n;
        eff_d.m   = regs_d.cpu_m;
        eff_d.prog = regs_d.ctrl[CTL_PROG_EN];
        if (rec_d && regs_d.ctrl[CTL_REC_SRC]) begin
            eff_d.prog = 1'b1;
            eff_d.n    = regs_d.rec_n;
            eff_d.m    = regs_d.rec_m;
        end else if (rec_d) begin
            eff_d.prog = 1'b0;
            eff_d.sel  = pins_q;
        end
        // In programmable mode, or in recovery with recovery source set, rewriting a divider byte reloads even with an equal value
        nm_upd = wr_stb & ((~rec_d & eff_d.prog & (ptr_q == REG_CPU_N || ptr_q == REG_CPU_M))
                 | (rec_d & regs_d.ctrl[CTL_REC_SRC]
                    & (ptr_q == REG_REC_N || ptr_q == REG_REC_M)));
        load_d  = nm_upd | (eff_d != eff_q);
        // Only host changes arm the watchdog; the recovery switch must not
        host_fc  = load_d & ~to_evt;
        fc_tgl_d = fc_tgl_q ^ host_fc;
        rstc_d   = (rstc_q != '0) ? rstc_q - RSTC_W'(1) : rstc_q;
        if ((to_evt & regs_q.ctrl[CTL_RST_WD]) | (host_fc & regs_d.ctrl[CTL_RST_FC])) begin
            rstc_d = RST_LEN;
        end
        rstn_d = (rstc_d == '0);
        // Handshake: new config only after the previous one was taken
        xcfg_d = xcfg_q;
        req_d  = req_q;
        wcfg_d = '{en: regs_d.ctrl[CTL_WATCHDOG_ENABLE], pre: regs_d.ctrl[CTL_WD_PRE], cnt: regs_d.wd_cnt};
        if (req_q == ack_s && wcfg_d != xcfg_q) begin
            xcfg_d = wcfg_d;
            req_d  = ~req_q;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            regs_q   <= '{ctrl: CTRL_RST, sel: SEL_RST, cpu_n: N_RST, cpu_m: M_RST,
                          rec_n: N_RST, rec_m: M_RST, wd_cnt: WD_CNT_RST};
            flag_q   <= 1'b0;
            rec_q    <= 1'b0;
            pins_q   <= 5'h00;
            lcnt_q   <= 2'h0;
            eff_q    <= '0;
            load_q   <= 1'b0;
            fc_tgl_q <= 1'b0;
            rstc_q   <= '0;
            rstn_q   <= 1'b1;
            xcfg_q   <= '0;
            req_q    <= 1'b0;
        end else begin
            regs_q   <= regs_d;
            flag_q   <= flag_d;
            rec_q    <= rec_d;
            pins_q   <= pins_d;
            lcnt_q   <= lcnt_d;
            eff_q    <= eff_d;
            load_q   <= load_d;
            fc_tgl_q <= fc_tgl_d;
            rstc_q   <= rstc_d;
            rstn_q   <= rstn_d;
            xcfg_q   <= xcfg_d;
            req_q    <= req_d;
        end
    end

    // ****************************************
    // Watchdog on the reference clock
    // ****************************************
    cfpw_wd_state_t     wst_q, wst_d;
    cfpw_wdcfg_t        rcfg_q, rcfg_d;
    logic [PRESC_W-1:0] presc_q, presc_d, unit_last;
    logic [5:0]         wcnt_q, wcnt_d, reload;
    logic               ack_d, to_tgl_d, fc_evt;

    always_comb begin
        rcfg_d   = rcfg_q;
        ack_d    = ack_q;
        wst_d    = wst_q;
        presc_d  = presc_q;
        wcnt_d   = wcnt_q;
        to_tgl_d = to_tgl_q;
        fc_evt   = fc_s ^ fc_p;
        if (req_s != ack_q) begin
            rcfg_d = xcfg_q;
            ack_d  = req_s;
        end
        unit_last = rcfg_d.pre ? LONG_LAST : SHORT_LAST;
        // Zero stands for 32 units, giving the full span
        reload    = {rcfg_d.cnt == 5'h00, rcfg_d.cnt};
        if (!rcfg_d.en) begin
            wst_d   = WD_OFF;
            presc_d = '0;
            wcnt_d  = reload;
        end else begin
            unique case (wst_q)
                WD_OFF, WD_ARM: begin
                    wst_d = fc_evt ? WD_RUN : WD_ARM;
                    presc_d = '0;
                    wcnt_d  = reload;
                end
                WD_RUN: begin
                    if (fc_evt) begin
                        presc_d = '0;
                        wcnt_d  = reload;
                    end else if (presc_q == unit_last) begin
                        presc_d = '0;
                        wcnt_d  = wcnt_q - 6'h01;
                        if (wcnt_q == 6'h01) begin
                            to_tgl_d = ~to_tgl_q;
                            wst_d    = WD_ARM;
                        end
                    end else begin
                        presc_d = presc_q + PRESC_W'(1);
                    end
                end
                default: wst_d = WD_OFF;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (rrst_s) begin
            rcfg_q   <= '0;
            ack_q    <= 1'b0;
            wst_q    <= WD_OFF;
            presc_q  <= '0;
            wcnt_q   <= 6'h00;
            to_tgl_q <= 1'b0;
        end else begin
            rcfg_q   <= rcfg_d;
            ack_q    <= ack_d;
            wst_q    <= wst_d;
            presc_q  <= presc_d;
            wcnt_q   <= wcnt_d;
            to_tgl_q <= to_tgl_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign SMB_DAT_OUT  = dout_q;
    assign SMB_DAT_OE_N = oen_q;
    assign FREQ_OUT     = eff_q;
    assign FREQ_LOAD    = load_q;
    assign SYS_RESET_N  = rstn_q;
    assign WD_TIMEOUT   = flag_q;

endmodule : cfpw_top

// File: tb/cfpw_monitor.sv
// Port assertions for cfpw_top.
// Assumes the host holds each SMBus clock phase at least 5 cycles.
`timescale 1ns/1ps
module cfpw_monitor
(
    input wire logic                 SYS_CLK,
    input wire logic                 SYS_RST,
    input wire logic                 SMB_CLK_IN,
    input wire logic                 SMB_DAT_OUT,
    input wire logic                 SMB_DAT_OE_N,
    input wire cfpw_pkg::cfpw_freq_t FREQ_OUT,
    input wire logic                 FREQ_LOAD,
    input wire logic                 SYS_RESET_N,
    input wire logic                 WD_TIMEOUT
);
    import cfpw_pkg::*;
    // ****************************************
    // Checks
    // ****************************************
    logic [3:0] since_ld_q, since_ld_d;
    always_comb begin
        since_ld_d = (since_ld_q == 4'hF) ? since_ld_q : since_ld_q + 4'h1;
        if (FREQ_LOAD) since_ld_d = 4'h0;
    end
    always_ff @(posedge SYS_CLK) begin
        since_ld_q <= SYS_RST ? 4'hF : since_ld_d;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    sequence low8_s;
        !SYS_RESET_N [*8];
    endsequence
    load_pulse_a: assert property (FREQ_LOAD |=> !FREQ_LOAD)
        else $error("load strobe too long");
    freq_load_a: assert property ($changed(FREQ_OUT) |-> FREQ_LOAD)
        else $error("setting changed without load");
    rst_width_a: assert property ($fell(SYS_RESET_N)
        |-> low8_s ##1 low8_s ##1 low8_s ##1 !SYS_RESET_N)
        else $error("reset pulse short");
    rst_cause_a: assert property ($fell(SYS_RESET_N)
        |-> ##[0:4] (WD_TIMEOUT || since_ld_q < 4'h8))
        else $error("reset pulse without cause");
    sda_open_a: assert property (!SMB_DAT_OUT)
        else $error("data pin driven high");
    sda_scl_a: assert property ($changed(SMB_DAT_OE_N) |-> !SMB_CLK_IN)
        else $error("data changed while clock high");
    ack_hold_a: assert property ($fell(SMB_DAT_OE_N) |-> !SMB_DAT_OE_N [*4])
        else $error("data low too short");
    flag_clear_a: assert property ($fell(WD_TIMEOUT) |-> !SMB_DAT_OE_N || !$past(SMB_DAT_OE_N))
        else $error("flag cleared without write");
endmodule : cfpw_monitor

bind cfpw_top cfpw_monitor u_mon (.SYS_CLK, .SYS_RST, .SMB_CLK_IN, .SMB_DAT_OUT,
    .SMB_DAT_OE_N, .FREQ_OUT, .FREQ_LOAD, .SYS_RESET_N, .WD_TIMEOUT);

// File: tb/cfpw_smb_host.sv
// SMBus host model for cfpw_top.
// Assumes the bench waits until reset has settled.
`timescale 1ns/1ps
module cfpw_smb_host
(
    input  wire logic sys_clk,
    input  wire logic dat_out,
    input  wire logic dat_oe_n,
    output logic      scl,
    output logic      sda
);
    import cfpw_pkg::*;
    // ****************************************
    // Bus phases
    // ****************************************
    logic sda_drv = 1'b1;
    initial scl = 1'b1;
    // Wired-and line, pull-up wins when nobody drives
    assign sda = sda_drv & (dat_oe_n | dat_out);
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // Data moves only after the clock is low, never with it
    task automatic bit_x(input logic b, output logic r);
        scl = 1'b0;
        tick(2);
        sda_drv = b;
        tick(4);
        scl = 1'b1;
        tick(3);
        r = sda;
        tick(3);
    endtask : bit_x
    task automatic cond(input logic a, input logic b);
        scl = 1'b0;
        tick(2);
        sda_drv = a;
        tick(4);
        scl = 1'b1;
        tick(6);
        sda_drv = b;
        tick(6);
    endtask : cond
    task automatic xbyte(input logic [7:0] tx, input logic nak, output logic [7:0] rx,
                         output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], r);
            rx[i] = r;
        end
        bit_x(nak, r);
        ack = ~r;
    endtask : xbyte
    task automatic reg_write(input logic [6:0] adr, input logic [7:0] cmd,
                             input logic [15:0] dat, input int nb, output logic ok);
        logic [7:0] rx;
        logic       a;
        cond(1'b1, 1'b0);
        xbyte({adr, 1'b0}, 1'b1, rx, ok);
        xbyte(cmd, 1'b1, rx, a);
        ok = ok & a;
        for (int i = 0; i < nb; i++) begin
            xbyte(dat[8*i +: 8], 1'b1, rx, a);
            ok = ok & a;
        end
        cond(1'b0, 1'b1);
    endtask : reg_write
    task automatic reg_read(input logic [7:0] cmd, output logic [7:0] d);
        logic a;
        cond(1'b1, 1'b0);
        xbyte({SMB_ADDR_DEF, 1'b0}, 1'b1, d, a);
        xbyte(cmd, 1'b1, d, a);
        cond(1'b1, 1'b0);
        xbyte({SMB_ADDR_DEF, 1'b1}, 1'b1, d, a);
        xbyte(8'hFF, 1'b1, d, a);
        cond(1'b0, 1'b1);
    endtask : reg_read
endmodule : cfpw_smb_host

// File: tb/cfpw_tb.sv
// Self-checking bench for cfpw_top.
// Assumes shortened prescaler units of 10 and 40 reference cycles.
`timescale 1ns/1ps
module cfpw_tb;
    import cfpw_pkg::*;
    // ****************************************
    // Harness
    // ****************************************
    logic       sys_clk  = 1'b0;
    logic       sys_rst  = 1'b1;
    logic       ref_clk  = 1'b0;
    logic [4:0] fs_pins  = 5'h13;
    logic       scl;
    logic       sda;
    logic       dat_out;
    logic       dat_oe_n;
    cfpw_freq_t freq;
    logic       load;
    logic       rst_n;
    logic       wd_to;
    logic       mark     = 1'b0;
    logic       to_q     = 1'b0;
    int         err_total   = 0;
    int         check_count = 0;
    int         cyc = 0;
    int         loads = 0;
    int         pulses = 0;
    int         low_run = 0, last_run = 0;
    int         t_ld = 0, t_to = 0;
    always #20 sys_clk = ~sys_clk;
    always #7.5 ref_clk = ~ref_clk;
    cfpw_top #(.PRE_SHORT_CYC(10), .PRE_LONG_CYC(40)) dut (.SYS_CLK(sys_clk),
        .SYS_RST(sys_rst), .REF_CLK(ref_clk), .FS_PINS(fs_pins), .SMB_CLK_IN(scl),
        .SMB_DAT_IN(sda), .SMB_DAT_OUT(dat_out), .SMB_DAT_OE_N(dat_oe_n),
        .FREQ_OUT(freq), .FREQ_LOAD(load), .SYS_RESET_N(rst_n), .WD_TIMEOUT(wd_to));
    cfpw_smb_host host (.sys_clk(sys_clk), .dat_out(dat_out), .dat_oe_n(dat_oe_n),
        .scl(scl), .sda(sda));
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (load === 1'b1) loads <= loads + 1;
        if (load === 1'b1 && mark) t_ld <= cyc;
        if (load === 1'b1) mark <= 1'b0;
        if (wd_to === 1'b1 && !to_q) t_to <= cyc;
        to_q <= (wd_to === 1'b1);
        low_run <= (rst_n === 1'b0) ? low_run + 1 : 0;
        if (rst_n === 1'b1 && low_run != 0) last_run <= low_run;
        if (rst_n === 1'b0 && low_run == 0) pulses <= pulses + 1;
        if (cyc == 60000) begin
            err_total = err_total + 1;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc
    task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int nb);
        logic ok;
        host.reg_write(SMB_ADDR_DEF, cmd, d, nb, ok);
        check(ok, 1'b1);
    endtask : wr
    task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] d;
        host.reg_read(cmd, d);
        check(d, exp);
    endtask : rd_chk
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic ok;
        check(freq, {1'b0, 5'h13, 15'h0000});
        for (int i = 0; i < 7; i++) rd_chk(i[7:0], 8'h00);
        rd_chk(REG_PINS, 8'h13);
        rd_chk(8'h20, 8'h00);
        host.reg_write(7'h15, REG_SEL, 16'h0005, 1, ok);
        check(ok, 1'b0);
        rd_chk(REG_SEL, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_prog();
        int n0;
        n0 = loads;
        wr(REG_CPU_N, 16'h5D61, 2);
        check(loads - n0, 2);
        wr(REG_CTRL, 16'h0001, 1);
        check(freq, {1'b1, 5'h13, 8'h61, 7'h5D});
        wr(REG_CPU_M, 16'h002D, 1);
        check(loads - n0, 4);
        wr(REG_SEL, 16'h000A, 1);
        wr(REG_CTRL, 16'h0003, 1);
        check(freq, {1'b1, 5'h0A, 8'h61, 7'h2D});
        $display("program test done");
    endtask : t_prog
    task automatic t_wd();
        logic [7:0] ctl;
        int         p0;
        int         lo;
        wr(REG_REC_N, 16'h2DF5, 2);
        wr(REG_WD_CNT, 16'h0002, 1);
        for (int i = 0; i < 2; i++) begin
            ctl = (i == 0) ? 8'h2F : 8'h1F;
            lo = ((i == 0) ? 10 : 40) * 2 * 15 / 40;
            wr(REG_CTRL, {8'h00, ctl | 8'h80}, 1);
            wait_cyc(150);
            check(wd_to, 1'b0);
            p0 = pulses;
            mark = 1'b1;
            wr(REG_CPU_N, {8'h00, 8'h70 + 8'(i)}, 1);
            for (int k = 0; k < 400 && wd_to !== 1'b1; k++) wait_cyc(1);
            wait_cyc(40);
            check(wd_to, 1'b1);
            check(freq, {1'b1, 5'h0A, 8'hF5, 7'h2D});
            check(t_to - t_ld >= lo && t_to - t_ld <= lo + 30, 1'b1);
            check(pulses - p0, (i == 0) ? 1 : 0);
            wr(REG_CTRL, {8'h00, ctl}, 1);
            rd_chk(REG_CTRL, ctl | 8'h80);
            wr(REG_CTRL, {8'h00, ctl | 8'h80}, 1);
            rd_chk(REG_CTRL, ctl);
        end
        $display("watchdog test done");
    endtask : t_wd
    task automatic t_rstfc();
        int p0;
        wr(REG_CTRL, 16'h0083, 1);
        check(freq[20:15], {1'b0, 5'h13});
        wr(REG_CTRL, 16'h0043, 1);
        p0 = pulses;
        wr(REG_CPU_N, 16'h0080, 1);
        wait_cyc(200);
        check(wd_to, 1'b0);
        check(pulses - p0, 1);
        check(last_run, 25);
        wr(REG_CTRL, 16'h0003, 1);
        wr(REG_CPU_N, 16'h0081, 1);
        wait_cyc(40);
        check(pulses - p0, 1);
        check(freq, {1'b1, 5'h0A, 8'h81, 7'h2D});
        $display("reset pulse test done");
    endtask : t_rstfc
    initial begin
        wait_cyc(12);
        sys_rst = 1'b0;
        wait_cyc(10);
        t_reset();
        t_prog();
        t_wd();
        t_rstfc();
        final_report();
    end
endmodule : cfpw_tb
